// file: hdl/codec_status_flag_bank.v
/*
  codec_status_flag_bank: read-only apb bank of power, gain-settled,
  latched (clear-on-read) overflow / event flags and live overflow flags.
  assumes status and event inputs are synchronous to clk_i; event inputs
  are levels or pulses, sampled every cycle.

*/
`timescale 1ns/1ps
`include "flag_bank_defs.vh"

module codec_status_flag_bank (
  input wire clk_i,
  input wire rstn_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // live power state
  input wire left_dac_pwr_i,
  input wire left_line_driver_pwr_i,
  input wire left_headphone_driver_pwr_i,
  input wire right_dac_pwr_i,
  input wire right_line_driver_pwr_i,
  input wire right_headphone_driver_pwr_i,
  // gain settled: applied gain equals programmed gain
  input wire left_dac_gain_settled_i,
  input wire right_dac_gain_settled_i,
  // overflow conditions (live levels)
  input wire left_dac_ovf_i,
  input wire right_dac_ovf_i,
  input wire left_adc_ovf_i,
  input wire right_adc_ovf_i,
  input wire playback_processor_core_ovf_i,
  input wire record_processor_core_ovf_i,
  // events
  input wire left_headphone_driver_oc_i,
  input wire right_headphone_driver_oc_i,
  input wire headset_button_i,
  input wire headset_plug_i,
  input wire left_range_compression_thr_i,
  input wire right_range_compression_thr_i,
  input wire playback_processor_core_int_std_i,
  input wire playback_processor_core_int_aux_i
);

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  wire [7:0] reg_idx;
  wire setup_rd;
  wire access_done;
  reg rd_clr_ovf;
  reg rd_clr_evt;

  assign reg_idx = paddr_i[`ADDR_W-1:`ADDR_LSB];
  // the read is captured in the setup cycle so data is ready with pready
  assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
  assign access_done = psel_i & penable_i & pready_o;

  // --------------------------------------------------------------------
  // live views of the status inputs
  // --------------------------------------------------------------------
  reg [7:0] power_view;
  reg [7:0] gain_view;
  reg [7:0] live_ovf;
  reg [7:0] evt_in;

  always @* begin
    power_view = `ZERO_BYTE;
    power_view[`BIT_PWR_LEFT_DAC] = left_dac_pwr_i;
    power_view[`BIT_PWR_LEFT_LINE] = left_line_driver_pwr_i;
    power_view[`BIT_PWR_LEFT_HP] = left_headphone_driver_pwr_i;
    power_view[`BIT_PWR_RIGHT_DAC] = right_dac_pwr_i;
    power_view[`BIT_PWR_RIGHT_LINE] = right_line_driver_pwr_i;
    power_view[`BIT_PWR_RIGHT_HP] = right_headphone_driver_pwr_i;
    gain_view = `ZERO_BYTE;
    gain_view[`BIT_GAIN_LEFT] = left_dac_gain_settled_i;
    gain_view[`BIT_GAIN_RIGHT] = right_dac_gain_settled_i;
    live_ovf = `ZERO_BYTE;
    live_ovf[`BIT_OVF_LEFT_DAC] = left_dac_ovf_i;
    live_ovf[`BIT_OVF_RIGHT_DAC] = right_dac_ovf_i;
    live_ovf[`BIT_OVF_LEFT_ADC] = left_adc_ovf_i;
    live_ovf[`BIT_OVF_RIGHT_ADC] = right_adc_ovf_i;
    live_ovf[`BIT_OVF_PLAYBACK] = playback_processor_core_ovf_i;
    live_ovf[`BIT_OVF_RECORD] = record_processor_core_ovf_i;
    evt_in = `ZERO_BYTE;
    evt_in[`BIT_EVT_OC_LEFT] = left_headphone_driver_oc_i;
    evt_in[`BIT_EVT_OC_RIGHT] = right_headphone_driver_oc_i;
    evt_in[`BIT_EVT_BUTTON] = headset_button_i;
    evt_in[`BIT_EVT_PLUG] = headset_plug_i;
    evt_in[`BIT_EVT_THR_LEFT] = left_range_compression_thr_i;
    evt_in[`BIT_EVT_THR_RIGHT] = right_range_compression_thr_i;
    evt_in[`BIT_EVT_INT_STD] = playback_processor_core_int_std_i;
    evt_in[`BIT_EVT_INT_AUX] = playback_processor_core_int_aux_i;
  end

  // --------------------------------------------------------------------
  // sticky flags
  // --------------------------------------------------------------------
  reg [7:0] latched_overflow_flags_q;
  reg [7:0] latched_overflow_flags_d;
  reg [7:0] latched_event_flags_q;
  reg [7:0] latched_event_flags_d;

  // set wins over clear so an event in the clearing cycle survives
  function [7:0] sticky_next;
    input [7:0] cur;
    input [7:0] set;
    input clr;
    begin
      sticky_next = (clr ? `ZERO_BYTE : cur) | set;
    end
  endfunction

  always @* begin
    latched_overflow_flags_d = sticky_next(latched_overflow_flags_q, live_ovf,
      rd_clr_ovf);
    latched_event_flags_d = sticky_next(latched_event_flags_q, evt_in,
      rd_clr_evt);
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latched_overflow_flags_q <= `RST_FLAGS;
      latched_event_flags_q <= `RST_FLAGS;
    end else begin
      latched_overflow_flags_q <= latched_overflow_flags_d;
      latched_event_flags_q <= latched_event_flags_d;
    end
  end

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  reg [7:0] rd_byte;
  reg rd_hit;

  always @* begin
    rd_byte = `ZERO_BYTE;
    rd_hit = 1'h1;
    case (reg_idx)
      `IDX_DAC_POWER_STATUS: rd_byte = power_view;
      `IDX_DAC_GAIN_SETTLED: rd_byte = gain_view;
      `IDX_LATCHED_OVERFLOW: rd_byte = latched_overflow_flags_d;
      `IDX_LIVE_OVERFLOW: rd_byte = live_ovf;
      `IDX_LATCHED_EVENT: rd_byte = latched_event_flags_d;
      default: begin
        if (reg_idx >= `IDX_RESERVED_FIRST && reg_idx <= `IDX_RESERVED_LAST) begin
          rd_byte = `ZERO_BYTE;
        end else begin
          rd_hit = 1'h0;
        end
      end
    endcase
  end

  // --------------------------------------------------------------------
  // apb response: one wait-free access phase; writes change nothing
  // --------------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= `RST_RDATA;
      pready_o <= 1'h0;
      pslverr_o <= 1'h0;
      rd_clr_ovf <= 1'h0;
      rd_clr_evt <= 1'h0;
    end else begin
      rd_clr_ovf <= 1'h0;
      rd_clr_evt <= 1'h0;
      if (psel_i & ~penable_i) begin
        pready_o <= 1'h1;
        // unmapped addresses answer with an error, writes are ignored
        pslverr_o <= ~rd_hit;
        if (setup_rd) begin
          // reads see the flags including an event of this cycle
          prdata_o <= {`ZERO_HI, rd_byte};
          rd_clr_ovf <= (reg_idx == `IDX_LATCHED_OVERFLOW);
          rd_clr_evt <= (reg_idx == `IDX_LATCHED_EVENT);
        end else begin
          prdata_o <= `RST_RDATA;
        end
      end else if (access_done) begin
        pready_o <= 1'h0;
        pslverr_o <= 1'h0;
      end
    end
  end

endmodule // codec_status_flag_bank

// file: hdl/flag_bank_defs.vh
/*
  register offsets, bit positions and reset values of the codec status and
  flag bank. assumes byte-addressed apb with one register per 32-bit word.
*/
`ifndef FLAG_BANK_DEFS_VH
`define FLAG_BANK_DEFS_VH

// ----------------------------------------------------------------------
// register indices (printed offsets) and byte-address split
// ----------------------------------------------------------------------
`define IDX_DAC_POWER_STATUS 8'h25
`define IDX_DAC_GAIN_SETTLED 8'h26
`define IDX_RESERVED_FIRST 8'h27
`define IDX_RESERVED_LAST 8'h29
`define IDX_LATCHED_OVERFLOW 8'h2a
`define IDX_LIVE_OVERFLOW 8'h2b
`define IDX_LATCHED_EVENT 8'h2c
`define ADDR_LSB 2
`define ADDR_W 10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_PWR_LEFT_DAC 7
`define BIT_PWR_LEFT_LINE 6
`define BIT_PWR_LEFT_HP 5
`define BIT_PWR_RIGHT_DAC 3
`define BIT_PWR_RIGHT_LINE 2
`define BIT_PWR_RIGHT_HP 1
`define BIT_GAIN_LEFT 4
`define BIT_GAIN_RIGHT 0
`define BIT_OVF_LEFT_DAC 7
`define BIT_OVF_RIGHT_DAC 6
`define BIT_OVF_PLAYBACK 5
`define BIT_OVF_LEFT_ADC 3
`define BIT_OVF_RIGHT_ADC 2
`define BIT_OVF_RECORD 1
`define BIT_EVT_OC_LEFT 7
`define BIT_EVT_OC_RIGHT 6
`define BIT_EVT_BUTTON 5
`define BIT_EVT_PLUG 4
`define BIT_EVT_THR_LEFT 3
`define BIT_EVT_THR_RIGHT 2
`define BIT_EVT_INT_STD 1
`define BIT_EVT_INT_AUX 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_FLAGS 8'h00
`define RST_RDATA 32'h0000_0000
`define ZERO_BYTE 8'h00
`define ZERO_HI 24'h00_0000

`endif

// file: tb/codec_status_flag_bank_chk.sv
/* apb timing and read-data assertions for the codec status flag bank.
   assumes a bind to codec_status_flag_bank, one clock, async low reset. */
`timescale 1ns/1ps
module codec_status_flag_bank_chk (
  input wire clk_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [9:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire left_dac_pwr_i,
  input wire left_dac_gain_settled_i,
  input wire right_dac_gain_settled_i,
  input wire left_dac_ovf_i,
  input wire headset_button_i
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  wire [7:0] idx = paddr_i[9:2];
  wire unmapped_w = idx < 8'h25 || idx > 8'h2c;
  wire rsv_w = idx >= 8'h27 && idx <= 8'h29;
  wire [31:0] gain_w = {27'h0, left_dac_gain_settled_i, 3'h0, right_dac_gain_settled_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence rd_s(logic [7:0] a);
    psel_i && !penable_i && !pwrite_i && idx == a;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready_o |-> $past(psel_i) && !$past(penable_i))
    else $error("ready without setup");
  power_read_a: assert property (rd_s(8'h25) |=> prdata_o[7] == $past(left_dac_pwr_i))
    else $error("power bit wrong");
  gain_read_a: assert property (rd_s(8'h26) |=> prdata_o == $past(gain_w))
    else $error("gain byte wrong");
  live_ovf_read_a: assert property (rd_s(8'h2b) |=> prdata_o[7] == $past(left_dac_ovf_i))
    else $error("live overflow bit wrong");
  reserved_zero_a: assert property (setup_s ##0 !pwrite_i && rsv_w |=> prdata_o == 32'h0)
    else $error("reserved not zero");
  write_quiet_a: assert property (setup_s ##0 pwrite_i |=> prdata_o == 32'h0)
    else $error("write returned data");
  slverr_map_a: assert property (setup_s |=> pslverr_o == $past(unmapped_w))
    else $error("slverr decode wrong");
  ovf_sticky_a: assert property (rd_s(8'h2a) ##0 left_dac_ovf_i |=> prdata_o[7])
    else $error("overflow not latched");
  button_sticky_a: assert property (rd_s(8'h2c) ##0 headset_button_i |=> prdata_o[5])
    else $error("button not latched");
endmodule // codec_status_flag_bank_chk

bind codec_status_flag_bank codec_status_flag_bank_chk chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .left_dac_pwr_i(left_dac_pwr_i), .left_dac_gain_settled_i(left_dac_gain_settled_i),
  .right_dac_gain_settled_i(right_dac_gain_settled_i), .left_dac_ovf_i(left_dac_ovf_i),
  .headset_button_i(headset_button_i));

// file: tb/tb_codec_status_flag_bank.sv
/* self-checking bench for the codec status flag bank.
   assumes zero-wait apb answers are awaited, never counted on. */
`timescale 1ns/1ps
module tb_codec_status_flag_bank;
  reg clk, rstn, psel, penable, pwrite, err;
  reg [9:0] paddr;
  reg [31:0] pwdata, rd, seed, r;
  reg [5:0] pw, ov;
  reg [1:0] gn;
  reg [7:0] ev;
  wire [31:0] prdata;
  wire pready, pslverr;
  integer fails = 0;
  integer total_checks = 0;
  integer i;
  codec_status_flag_bank dut (.clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .left_dac_pwr_i(pw[5]),
    .left_line_driver_pwr_i(pw[4]), .left_headphone_driver_pwr_i(pw[3]),
    .right_dac_pwr_i(pw[2]), .right_line_driver_pwr_i(pw[1]),
    .right_headphone_driver_pwr_i(pw[0]), .left_dac_gain_settled_i(gn[1]),
    .right_dac_gain_settled_i(gn[0]), .left_dac_ovf_i(ov[5]), .right_dac_ovf_i(ov[4]),
    .playback_processor_core_ovf_i(ov[3]), .left_adc_ovf_i(ov[2]), .right_adc_ovf_i(ov[1]),
    .record_processor_core_ovf_i(ov[0]), .left_headphone_driver_oc_i(ev[7]),
    .right_headphone_driver_oc_i(ev[6]), .headset_button_i(ev[5]), .headset_plug_i(ev[4]),
    .left_range_compression_thr_i(ev[3]), .right_range_compression_thr_i(ev[2]),
    .playback_processor_core_int_std_i(ev[1]), .playback_processor_core_int_aux_i(ev[0]));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // bit 4 and bit 0 are reserved in both six-flag layouts
  function [31:0] pack6(input [5:0] v);
    pack6 = {24'h0, v[5:3], 1'h0, v[2:0], 1'h0};
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a);
    begin
      @(posedge clk);
      seed = xs(seed);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {a, 2'h0};
      pwdata <= pack6(seed[5:0]);
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] exp);
    begin
      apb(1'h0, a);
      check(rd, exp);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 5000);
    fails = fails + 1;
    finish_test;
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, pw, gn, ov, ev} = 0;
    seed = 32'he8db;
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    for (i = 8'h24; i <= 8'h2d; i = i + 1) begin
      rdchk(i[7:0], 32'h0);
      check({31'h0, err}, {31'h0, i < 8'h25 || i > 8'h2c});
    end
    $display("reset and map test done");
    for (i = 0; i < 24; i = i + 1) begin
      seed = xs(seed);
      // apb draws its own write data from seed, so keep this draw apart
      r = seed;
      pw <= r[5:0];
      gn <= r[7:6];
      ov <= r[13:8];
      rdchk(8'h25, pack6(r[5:0]));
      rdchk(8'h26, {27'h0, r[7], 3'h0, r[6]});
      rdchk(8'h2b, pack6(r[13:8]));
    end
    ov <= 6'h0;
    apb(1'h0, 8'h2a);
    apb(1'h0, 8'h2c);
    $display("live status test done");
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      r = seed;
      @(posedge clk);
      ov <= r[5:0];
      ev <= r[15:8];
      @(posedge clk);
      ov <= 6'h0;
      ev <= 8'h0;
      apb(1'h1, 8'h2a);
      check(rd, 32'h0);
      rdchk(8'h2a, pack6(r[5:0]));
      rdchk(8'h2a, 32'h0);
      rdchk(8'h2c, {24'h0, r[15:8]});
      rdchk(8'h2c, 32'h0);
    end
    $display("sticky test done");
    ov <= 6'h20;
    rdchk(8'h2a, 32'h80);
    ov <= 6'h0;
    rdchk(8'h2a, 32'h80);
    rdchk(8'h2a, 32'h0);
    ev <= 8'hff;
    @(posedge clk);
    ev <= 8'h0;
    rstn <= 1'h0;
    @(posedge clk);
    rstn <= 1'h1;
    rdchk(8'h2c, 32'h0);
    $display("clash and reset test done");
    finish_test;
  end
endmodule // tb_codec_status_flag_bank
